//--- rtl/fdp_slave_port.v
// fdp_slave_port: dp slave telegram engine with io, config and diagnostic stores
// assumes an rs-485 transceiver on line_* and island logic on mclk_in
`timescale 1ns/1ps
`default_nettype none
`include "fdp_defs.vh"
module fdp_slave_port #(
  parameter        DIAG_MAX = 64,
  parameter [15:0] IDENT    = 16'h0000, // arbitrary value
  parameter [3:0]  LOCK_EDGES = 4'h8
) (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // fieldbus line
  input  wire        line_rx_in,
  output wire        line_tx_out,
  output reg         line_tx_en_out,
  // station address switches
  input  wire [6:0]  station_addr_in,
  // input image from the island
  input  wire        in_wr_in,
  input  wire [7:0]  in_idx_in,
  input  wire [7:0]  in_byte_in,
  input  wire [7:0]  in_len_in,
  // output image to the island
  input  wire [7:0]  out_idx_in,
  output reg  [7:0]  out_byte_out,
  input  wire [7:0]  out_len_in,
  output reg         out_update_out,
  // expected configuration
  input  wire [7:0]  cfg_len_in,
  input  wire [7:0]  cfg_sum_in,
  // island status
  input  wire        node_fault_in,
  input  wire [31:0] mod_fault_in,
  input  wire        chan_wr_in,
  input  wire        chan_clr_in,
  input  wire [23:0] chan_entry_in,
  // state
  output reg         exchange_out,
  output reg         frozen_out,
  output wire        baud_locked_out
);
  localparam P_IDLE = 3'h0, P_LE = 3'h1, P_LER = 3'h2, P_SD = 3'h3;
  localparam P_BODY = 3'h4, P_FCS = 3'h5, P_ED = 3'h6;
  localparam DX_PRM = 2'h0, DX_CFG = 2'h1, DX_DATA = 2'h2;
  localparam K_NONE = 2'h0, K_SC = 2'h1, K_DATA = 2'h2;
  localparam S_IN = 2'h0, S_OUT = 2'h1, S_CFG = 2'h2, S_DIAG = 2'h3;
  localparam T_IDLE = 2'h0, T_WAIT = 2'h1, T_SEND = 2'h2, T_DONE = 2'h3;
  localparam [7:0] CH_FIT = (DIAG_MAX - 11) / 3;

  integer i;
  reg [6:0]  addr_s1_q, addr_s2_q, addr_q;
  reg        rx_s1_q, rx_s2_q;
  reg [7:0]  rbuf_q [0:`FDP_LE_MAX-1];
  reg [7:0]  in_q   [0:`FDP_IO_MAX-1];
  reg [7:0]  out_q  [0:`FDP_IO_MAX-1];
  reg [7:0]  cfg_q  [0:`FDP_CFG_MAX-1];
  reg [23:0] chan_q [0:`FDP_CH_MAX-1];
  reg [3:0]  chan_cnt_q;
  reg [2:0]  pst_q;
  reg [7:0]  le_q, ridx_q, rfcs_q, cfg_len_q, mst_q;
  reg [1:0]  dx_q, tst_q, rsp_kind_q, rsp_src_q;
  reg [7:0]  rsp_len_q, rsp_fc_q, rsp_da_q, rsp_dsap_q, rsp_ssap_q, tidx_q, tfcs_q;
  reg        rsp_sap_q, prm_bad_q, cfg_bad_q, clear_q;
  reg [17:0] wcnt_q;
  reg [3:0]  errs_q;
  wire [13:0] div;
  wire        locked, rxv, rxe, txbusy;
  wire [7:0]  rxb;

  // two-stage synchroniser for the line pin, three stages for the address pins
  always @(posedge mclk_in) begin
    rx_s1_q   <= line_rx_in;
    rx_s2_q   <= rx_s1_q;
    addr_s1_q <= station_addr_in;
    addr_s2_q <= addr_s1_q;
    addr_q    <= addr_s2_q;
  end

  wire addr_ok = addr_q >= `FDP_ADDR_MIN && addr_q <= `FDP_ADDR_MAX;
  wire relock  = errs_q == `FDP_RELOCK_ERRS;

  fdp_baud_detect #(.LOCK_EDGES(LOCK_EDGES)) u_baud (
    .mclk_in    (mclk_in),
    .rst_n_in   (rst_n_in),
    .rx_in      (rx_s2_q),
    .relock_in  (relock),
    .div_out    (div),
    .locked_out (locked)
  );

  wire tx_go = tst_q == T_SEND && !txbusy;
  reg  [7:0] tbyte;

  fdp_uart u_uart (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in && locked),
    .div_in       (div),
    .rx_in        (rx_s2_q),
    .tx_out       (line_tx_out),
    .tx_go_in     (tx_go),
    .tx_byte_in   (tbyte),
    .tx_busy_out  (txbusy),
    .rx_valid_out (rxv),
    .rx_err_out   (rxe),
    .rx_byte_out  (rxb)
  );

  // decode of a received telegram
  wire       rx_ok  = rxv && tst_q == T_IDLE;
  wire       sap_f  = rbuf_q[0][7];
  wire [7:0] dlen   = sap_f ? le_q - 8'h05 : le_q - 8'h03;
  wire       to_me  = rbuf_q[0][6:0] == addr_q;
  wire       bcast  = rbuf_q[0][6:0] == `FDP_ADDR_BCAST;
  wire       go     = rx_ok && pst_q == P_ED && rxb == `FDP_ED && addr_ok && (to_me || bcast);
  wire [8:0] io_sum = {1'b0, in_len_in} + {1'b0, out_len_in};
  wire       io_ok  = in_len_in <= `FDP_IO_MAX && out_len_in <= `FDP_IO_MAX && io_sum <= `FDP_IO_MAX;
  reg  [7:0] cfg_sum;

  always @* begin
    cfg_sum = 8'h00;
    for (i = 0; i < `FDP_CFG_MAX; i = i + 1)
      if (i < dlen)
        cfg_sum = cfg_sum + rbuf_q[i+5];
  end

  wire cfg_match = dlen != 8'h00 && dlen <= `FDP_CFG_MAX && dlen == cfg_len_in && cfg_sum == cfg_sum_in && io_ok;

  wire [7:0] chan_n   = {4'h0, chan_cnt_q};
  wire [7:0] nshow    = chan_n < CH_FIT ? chan_n : CH_FIT;
  wire [7:0] diag_len = `FDP_DIAG_FIX + {nshow[6:0], 1'b0} + nshow;
  reg [1:0] nk, nsrc, nst;
  reg [7:0] nlen, nfc;
  reg       commit, prm_ok, prm_bad, cfg_ok, cfg_bad, gc;

  always @* begin
    nk = K_NONE; nsrc = S_IN; nlen = 8'h00; nfc = `FDP_FC_DL; nst = dx_q;
    commit = 1'b0; prm_ok = 1'b0; prm_bad = 1'b0; cfg_ok = 1'b0; cfg_bad = 1'b0; gc = 1'b0;
    if (!sap_f) begin
      nk = K_DATA;
      if (dx_q == DX_DATA && dlen == out_len_in) begin
        commit = 1'b1;
        nlen   = in_len_in;
      end else begin
        nfc = `FDP_FC_RS;
      end
    end else if (le_q >= 8'h05) begin
      case (rbuf_q[3])
        `FDP_SAP_PRM: begin
          nk = K_SC;
          if (dlen >= `FDP_STD_PRM && dlen <= `FDP_STD_PRM + `FDP_USR_PRM_MAX) begin
            nst = DX_CFG; prm_ok = 1'b1;
          end else begin
            nst = DX_PRM; prm_bad = 1'b1;
          end
        end
        `FDP_SAP_CFG: begin
          nk = K_SC;
          if (dx_q != DX_PRM && cfg_match) begin
            nst = DX_DATA; cfg_ok = 1'b1;
          end else begin
            nst = DX_PRM; cfg_bad = 1'b1;
          end
        end
        `FDP_SAP_GCFG:  begin nk = K_DATA; nsrc = S_CFG;  nlen = cfg_len_q; end
        `FDP_SAP_DIAG:  begin nk = K_DATA; nsrc = S_DIAG; nlen = diag_len; end
        `FDP_SAP_RDIN:  begin nk = K_DATA; nsrc = S_IN;   nlen = in_len_in; end
        `FDP_SAP_RDOUT: begin nk = K_DATA; nsrc = S_OUT;  nlen = out_len_in; end
        `FDP_SAP_GC:    gc = 1'b1;
        default: ;
      endcase
    end
    if (bcast)
      nk = K_NONE;
  end

  // telegram receiver
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pst_q <= P_IDLE; le_q <= 8'h00; ridx_q <= 8'h00; rfcs_q <= 8'h00; errs_q <= 4'h0;
    end else begin
      if (rxe)
        errs_q <= relock ? 4'h0 : errs_q + 4'h1;
      else if (rxv || relock)
        errs_q <= 4'h0;
      if (rxe)
        pst_q <= P_IDLE;
      else if (rx_ok) begin
        case (pst_q)
          P_IDLE: if (rxb == `FDP_SD2) pst_q <= P_LE;
          P_LE: begin
            le_q  <= rxb;
            pst_q <= (rxb >= `FDP_LE_MIN && rxb <= `FDP_LE_MAX) ? P_LER : P_IDLE;
          end
          P_LER: pst_q <= (rxb == le_q) ? P_SD : P_IDLE;
          P_SD: begin
            ridx_q <= 8'h00;
            rfcs_q <= 8'h00;
            pst_q  <= (rxb == `FDP_SD2) ? P_BODY : P_IDLE;
          end
          P_BODY: begin
            rbuf_q[ridx_q] <= rxb;
            rfcs_q <= rfcs_q + rxb;
            ridx_q <= ridx_q + 8'h01;
            if (ridx_q == le_q - 8'h01)
              pst_q <= P_FCS;
          end
          P_FCS: pst_q <= (rxb == rfcs_q) ? P_ED : P_IDLE;
          default: pst_q <= P_IDLE;
        endcase
      end
    end
  end

  // slave state, faults, freeze and clear
  always @(posedge mclk_in) begin
    out_update_out <= go && commit;
    clear_q        <= go && gc && dx_q == DX_DATA && rbuf_q[5][`FDP_GC_CLEAR];
    if (!rst_n_in || relock) begin
      dx_q <= DX_PRM; prm_bad_q <= 1'b0; cfg_bad_q <= 1'b0; frozen_out <= 1'b0;
      mst_q <= 8'hff; cfg_len_q <= 8'h00; exchange_out <= 1'b0;
    end else begin
      exchange_out <= dx_q == DX_DATA;
      if (go && !bcast) begin
        dx_q <= nst;
        if (prm_ok) begin prm_bad_q <= 1'b0; mst_q <= {1'b0, rbuf_q[1][6:0]}; end
        if (prm_bad) prm_bad_q <= 1'b1;
        if (cfg_ok) begin cfg_bad_q <= 1'b0; cfg_len_q <= dlen; end
        if (cfg_bad) cfg_bad_q <= 1'b1;
      end
      if (go && gc && dx_q == DX_DATA) begin
        if (rbuf_q[5][`FDP_GC_FREEZE])
          frozen_out <= 1'b1;
        else if (rbuf_q[5][`FDP_GC_UNFREEZE])
          frozen_out <= 1'b0;
      end
    end
  end

  // data stores
  genvar g;
  generate
    for (g = 0; g < `FDP_IO_MAX; g = g + 1) begin : g_io
      always @(posedge mclk_in) begin
        if (!rst_n_in || clear_q)
          out_q[g] <= 8'h00;
        else if (go && commit && g < out_len_in)
          out_q[g] <= rbuf_q[g+3];
        if (!rst_n_in)
          in_q[g] <= 8'h00;
        else if (in_wr_in && !frozen_out && in_idx_in == g)
          in_q[g] <= in_byte_in;
      end
    end
    for (g = 0; g < `FDP_CFG_MAX; g = g + 1) begin : g_cfg
      always @(posedge mclk_in)
        if (go && cfg_ok && !bcast)
          cfg_q[g] <= rbuf_q[g+5];
    end
  endgenerate

  always @(posedge mclk_in) begin
    out_byte_out <= out_idx_in < `FDP_IO_MAX ? out_q[out_idx_in] : 8'h00;
    if (!rst_n_in || chan_clr_in)
      chan_cnt_q <= 4'h0;
    else if (chan_wr_in && chan_cnt_q < `FDP_CH_MAX) begin
      chan_q[chan_cnt_q] <= chan_entry_in;
      chan_cnt_q <= chan_cnt_q + 4'h1;
    end
  end

  // diagnostic block
  wire       ext_diag = node_fault_in || mod_fault_in != 32'h0000_0000 || chan_cnt_q != 4'h0;
  reg  [7:0] di, ce_i, dbyte;
  reg  [23:0] ce;

  always @* begin
    ce_i = (di - `FDP_DIAG_FIX) / 8'h03;
    ce   = chan_q[ce_i[3:0]];
    case (di)
      8'h00: dbyte = {1'b0, prm_bad_q, 2'b00, ext_diag, cfg_bad_q, dx_q != DX_DATA, 1'b0};
      8'h01: dbyte = {5'b00000, 1'b1, 1'b0, dx_q == DX_PRM};
      8'h02: dbyte = {chan_n > CH_FIT, 7'h00};
      8'h03: dbyte = mst_q;
      8'h04: dbyte = IDENT[15:8];
      8'h05: dbyte = IDENT[7:0];
      8'h06: dbyte = `FDP_MOD_HDR;
      8'h07: dbyte = mod_fault_in[7:0];
      8'h08: dbyte = mod_fault_in[15:8];
      8'h09: dbyte = mod_fault_in[23:16];
      8'h0a: dbyte = mod_fault_in[31:24];
      default: begin
        case ((di - `FDP_DIAG_FIX) % 8'h03)
          8'h00:   dbyte = ce[7:0];
          8'h01:   dbyte = ce[15:8];
          default: dbyte = ce[23:16];
        endcase
      end
    endcase
  end

  // response builder
  wire [3:0] hl   = rsp_sap_q ? `FDP_HDR_SAP : `FDP_HDR_DEF;
  wire [7:0] tend = {4'h0, hl} + rsp_len_q;
  wire [7:0] tlen = rsp_len_q + {4'h0, hl} - 8'h04;

  always @* begin
    di = tidx_q - {4'h0, hl};
    if (rsp_kind_q == K_SC)
      tbyte = `FDP_SC;
    else if (tidx_q == 8'h00 || tidx_q == 8'h03)
      tbyte = `FDP_SD2;
    else if (tidx_q < 8'h03)
      tbyte = tlen;
    else if (tidx_q == 8'h04)
      tbyte = rsp_da_q;
    else if (tidx_q == 8'h05)
      tbyte = {rsp_sap_q, addr_q};
    else if (tidx_q == 8'h06)
      tbyte = rsp_fc_q;
    else if (tidx_q == 8'h07 && rsp_sap_q)
      tbyte = rsp_dsap_q;
    else if (tidx_q == 8'h08 && rsp_sap_q)
      tbyte = rsp_ssap_q;
    else if (tidx_q == tend)
      tbyte = tfcs_q;
    else if (tidx_q > tend)
      tbyte = `FDP_ED;
    else begin
      case (rsp_src_q)
        S_IN:    tbyte = in_q[di];
        S_OUT:   tbyte = out_q[di];
        S_CFG:   tbyte = cfg_q[di];
        default: tbyte = dbyte;
      endcase
    end
  end

  // response sequencer: answers only after a request, after the turnaround gap
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tst_q <= T_IDLE; tidx_q <= 8'h00; tfcs_q <= 8'h00; wcnt_q <= 18'h00000;
      rsp_kind_q <= K_NONE; rsp_src_q <= S_IN; rsp_len_q <= 8'h00; rsp_fc_q <= 8'h00;
      rsp_da_q <= 8'h00; rsp_dsap_q <= 8'h00; rsp_ssap_q <= 8'h00; rsp_sap_q <= 1'b0;
      line_tx_en_out <= 1'b0;
    end else begin
      line_tx_en_out <= tst_q == T_SEND || tst_q == T_DONE;
      case (tst_q)
        T_IDLE: if (go && nk != K_NONE) begin
          tst_q      <= T_WAIT;
          wcnt_q     <= `FDP_TSDR_BITS * {4'h0, div};
          rsp_kind_q <= nk;
          rsp_src_q  <= nsrc;
          rsp_len_q  <= nlen;
          rsp_fc_q   <= nfc;
          rsp_sap_q  <= sap_f;
          rsp_da_q   <= {sap_f, rbuf_q[1][6:0]};
          rsp_dsap_q <= rbuf_q[4];
          rsp_ssap_q <= rbuf_q[3];
          tidx_q     <= 8'h00;
          tfcs_q     <= 8'h00;
        end
        T_WAIT: begin
          wcnt_q <= wcnt_q - 18'h00001;
          if (wcnt_q == 18'h00000)
            tst_q <= T_SEND;
        end
        T_SEND: if (tx_go) begin
          tidx_q <= tidx_q + 8'h01;
          if (tidx_q >= 8'h04 && tidx_q < tend)
            tfcs_q <= tfcs_q + tbyte;
          if (rsp_kind_q == K_SC || tidx_q > tend)
            tst_q <= T_DONE;
        end
        default: if (!txbusy) tst_q <= T_IDLE;
      endcase
    end
  end

  assign baud_locked_out = locked;
endmodule // fdp_slave_port
`default_nettype wire

//--- common/fdp_defs.vh
// fdp_defs.vh: shared constants of the fieldbus dp slave port
// assumes a 100 mhz mclk_in and an rs-485 transceiver outside the block
`ifndef FDP_DEFS_VH
`define FDP_DEFS_VH
// clock and line rates
`define FDP_CLK_HZ      100000000
`define FDP_R9600       9600
`define FDP_R19200      19200
`define FDP_R45450      45450
`define FDP_R93750      93750
`define FDP_R187500     187500
`define FDP_R500K       500000
`define FDP_R1M5        1500000
`define FDP_R3M         3000000
`define FDP_R6M         6000000
`define FDP_R12M        12000000
`define FDP_DIV(r)      (`FDP_CLK_HZ / (r))
`define FDP_MID(a, b)   ((`FDP_DIV(a) + `FDP_DIV(b)) / 2)
// character framing: start, 8 data, even parity, stop
`define FDP_UART_STOP   4'ha
// telegram delimiters and codes
`define FDP_SD2         8'h68
`define FDP_ED          8'h16
`define FDP_SC          8'he5
`define FDP_FC_DL       8'h08
`define FDP_FC_RS       8'h0c
`define FDP_LE_MIN      8'h03
`define FDP_LE_MAX      8'hf9
`define FDP_HDR_SAP     4'h9
`define FDP_HDR_DEF     4'h7
`define FDP_TSDR_BITS   18'h0_000b
// service access points
`define FDP_SAP_RDIN    8'h38
`define FDP_SAP_RDOUT   8'h39
`define FDP_SAP_GC      8'h3a
`define FDP_SAP_GCFG    8'h3b
`define FDP_SAP_DIAG    8'h3c
`define FDP_SAP_PRM     8'h3d
`define FDP_SAP_CFG     8'h3e
// global control bits
`define FDP_GC_CLEAR    1
`define FDP_GC_UNFREEZE 2
`define FDP_GC_FREEZE   3
// addresses and limits
`define FDP_ADDR_MIN    7'h01
`define FDP_ADDR_MAX    7'h7d
`define FDP_ADDR_BCAST  7'h7f
`define FDP_IO_MAX      240
`define FDP_STD_PRM     8'h07
`define FDP_USR_PRM_MAX 8'h08
`define FDP_CFG_MAX     208
`define FDP_CH_MAX      14
`define FDP_DIAG_FIX    8'h0b
`define FDP_MOD_HDR     8'h45
`define FDP_RELOCK_ERRS 4'h4
`endif

//--- rtl/fdp_baud_detect.v
// fdp_baud_detect: finds the line bit rate from the shortest low run
// assumes rx_in is already synchronised to mclk_in
`timescale 1ns/1ps
`default_nettype none
`include "fdp_defs.vh"
module fdp_baud_detect #(
  parameter LOCK_EDGES = 4'h8
) (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // line and control
  input  wire        rx_in,
  input  wire        relock_in,
  // result
  output wire [13:0] div_out,
  output wire        locked_out
);
  reg [15:0] run_q;
  reg [15:0] min_q;
  reg [3:0]  edges_q;
  reg        prev_q;
  reg        locked_q;
  reg [13:0] div_q;

  function [13:0] snap;
    input [15:0] m;
    reg   [31:0] v;
    begin
      if (m < `FDP_MID(`FDP_R12M, `FDP_R6M))           v = `FDP_DIV(`FDP_R12M);
      else if (m < `FDP_MID(`FDP_R6M, `FDP_R3M))       v = `FDP_DIV(`FDP_R6M);
      else if (m < `FDP_MID(`FDP_R3M, `FDP_R1M5))      v = `FDP_DIV(`FDP_R3M);
      else if (m < `FDP_MID(`FDP_R1M5, `FDP_R500K))    v = `FDP_DIV(`FDP_R1M5);
      else if (m < `FDP_MID(`FDP_R500K, `FDP_R187500)) v = `FDP_DIV(`FDP_R500K);
      else if (m < `FDP_MID(`FDP_R187500, `FDP_R93750)) v = `FDP_DIV(`FDP_R187500);
      else if (m < `FDP_MID(`FDP_R93750, `FDP_R45450)) v = `FDP_DIV(`FDP_R93750);
      else if (m < `FDP_MID(`FDP_R45450, `FDP_R19200)) v = `FDP_DIV(`FDP_R45450);
      else if (m < `FDP_MID(`FDP_R19200, `FDP_R9600))  v = `FDP_DIV(`FDP_R19200);
      else                                             v = `FDP_DIV(`FDP_R9600);
      snap = v[13:0];
    end
  endfunction

  always @(posedge mclk_in) begin
    if (!rst_n_in || relock_in) begin
      run_q    <= 16'h0000;
      min_q    <= 16'hffff;
      edges_q  <= 4'h0;
      prev_q   <= 1'b1;
      locked_q <= 1'b0;
      div_q    <= snap(16'hffff);
    end else begin
      prev_q <= rx_in;
      if (!rx_in && run_q != 16'hffff)
        run_q <= run_q + 16'h0001;
      if (rx_in && !prev_q) begin
        run_q <= 16'h0000;
        if (run_q < min_q)
          min_q <= run_q;
        if (!locked_q)
          edges_q <= edges_q + 4'h1;
      end
      if (!locked_q && edges_q == LOCK_EDGES) begin
        locked_q <= 1'b1;
        div_q    <= snap(min_q);
      end
    end
  end

  assign div_out    = div_q;
  assign locked_out = locked_q;
endmodule // fdp_baud_detect
`default_nettype wire

//--- rtl/fdp_uart.v
// fdp_uart: 11-bit character receiver and transmitter, even parity
// assumes rx_in is synchronised and div_in holds clocks per bit
`timescale 1ns/1ps
`default_nettype none
`include "fdp_defs.vh"
module fdp_uart (
  // clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // bit timing
  input  wire [13:0] div_in,
  // line side
  input  wire        rx_in,
  output wire        tx_out,
  // byte side
  input  wire        tx_go_in,
  input  wire [7:0]  tx_byte_in,
  output wire        tx_busy_out,
  output reg         rx_valid_out,
  output reg         rx_err_out,
  output reg  [7:0]  rx_byte_out
);
  reg [13:0] rcnt_q;
  reg [3:0]  rbit_q;
  reg        rbusy_q;
  reg [8:0]  rsh_q;
  reg [13:0] tcnt_q;
  reg [3:0]  tbit_q;
  reg        tbusy_q;
  reg [10:0] tsh_q;

  // receiver samples mid bit
  always @(posedge mclk_in) begin
    rx_valid_out <= 1'b0;
    rx_err_out   <= 1'b0;
    if (!rst_n_in) begin
      rbusy_q     <= 1'b0;
      rcnt_q      <= 14'h0000;
      rbit_q      <= 4'h0;
      rsh_q       <= 9'h000;
      rx_byte_out <= 8'h00;
    end else if (!rbusy_q) begin
      if (!rx_in) begin
        rbusy_q <= 1'b1;
        rcnt_q  <= {1'b0, div_in[13:1]};
        rbit_q  <= 4'h0;
      end
    end else if (rcnt_q != 14'h0000) begin
      rcnt_q <= rcnt_q - 14'h0001;
    end else begin
      rcnt_q <= div_in - 14'h0001;
      rbit_q <= rbit_q + 4'h1;
      if (rbit_q == 4'h0) begin
        if (rx_in)
          rbusy_q <= 1'b0;
      end else if (rbit_q < `FDP_UART_STOP) begin
        rsh_q <= {rx_in, rsh_q[8:1]};
      end else begin
        rbusy_q     <= 1'b0;
        rx_byte_out <= rsh_q[7:0];
        if (rx_in && !(^rsh_q))
          rx_valid_out <= 1'b1;
        else
          rx_err_out <= 1'b1;
      end
    end
  end

  // transmitter shifts start, data, parity, stop
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tbusy_q <= 1'b0;
      tsh_q   <= 11'h7ff;
      tcnt_q  <= 14'h0000;
      tbit_q  <= 4'h0;
    end else if (!tbusy_q) begin
      if (tx_go_in) begin
        tbusy_q <= 1'b1;
        tsh_q   <= {1'b1, ^tx_byte_in, tx_byte_in, 1'b0};
        tcnt_q  <= div_in - 14'h0001;
        tbit_q  <= 4'h0;
      end
    end else if (tcnt_q != 14'h0000) begin
      tcnt_q <= tcnt_q - 14'h0001;
    end else begin
      tcnt_q <= div_in - 14'h0001;
      tsh_q  <= {1'b1, tsh_q[10:1]};
      tbit_q <= tbit_q + 4'h1;
      if (tbit_q == `FDP_UART_STOP)
        tbusy_q <= 1'b0;
    end
  end

  assign tx_out      = tsh_q[0];
  assign tx_busy_out = tbusy_q;
endmodule // fdp_uart
`default_nettype wire

//--- verif/fdp_port_checker.sv
// fdp_port_checker: line and state checks on the slave port pins
// assumes binding to fdp_slave_port, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fdp_port_checker (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic       line_tx_out,
  input wire logic       line_tx_en_out,
  input wire logic [7:0] out_idx_in,
  input wire logic [7:0] out_byte_out,
  input wire logic       out_update_out,
  input wire logic       exchange_out,
  input wire logic       frozen_out,
  input wire logic       baud_locked_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_idle_line_high: assert property (!line_tx_en_out |-> line_tx_out)
    else $error("line low while idle");
  a_reply_start_bit: assert property ($rose(line_tx_en_out) |-> ##[1:3] !line_tx_out)
    else $error("no start bit after enable");
  a_reply_holds: assert property ($rose(line_tx_en_out) |-> line_tx_en_out [*8])
    else $error("enable dropped early");
  a_reply_locked: assert property ($rose(line_tx_en_out) |-> baud_locked_out)
    else $error("reply without lock");
  a_update_pulse: assert property (out_update_out |=> !out_update_out)
    else $error("update longer than one cycle");
  a_update_in_exch: assert property (out_update_out |-> exchange_out)
    else $error("update outside exchange");
  a_freeze_in_exch: assert property ($rose(frozen_out) |-> exchange_out)
    else $error("freeze outside exchange");
  a_out_beyond_zero: assert property (out_idx_in >= 8'hf0 |=> out_byte_out == 8'h00)
    else $error("output byte beyond limit");
  a_exch_locked: assert property ($rose(exchange_out) |-> baud_locked_out)
    else $error("exchange without lock");
endmodule // fdp_port_checker
bind fdp_slave_port fdp_port_checker u_chk (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .line_tx_out(line_tx_out),
  .line_tx_en_out(line_tx_en_out), .out_idx_in(out_idx_in), .out_byte_out(out_byte_out),
  .out_update_out(out_update_out), .exchange_out(exchange_out), .frozen_out(frozen_out),
  .baud_locked_out(baud_locked_out));
`default_nettype wire

//--- verif/fdp_master_model.sv
// fdp_master_model: dp master sending telegrams on the slave receive line
// assumes the bench calls its tasks; 3 Mbit/s characters, idle high
`timescale 1ns/1ps
`default_nettype none
module fdp_master_model #(
  parameter real BIT_NS = 333.333
) (
  output var logic line_out
);
  initial line_out = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out = f[i];
      #(BIT_NS);
    end
  endtask
  task automatic lock_seq;
    send_byte(8'h55);
    send_byte(8'h55);
  endtask
  // one poll: idle gap, then a whole telegram
  task automatic send_tel(input logic [7:0] da, sa, fc, input logic [7:0] d[$]);
    logic [7:0] s;
    logic [7:0] t[$];
    #(BIT_NS * 33);
    s = da + sa + fc;
    foreach (d[i]) s += d[i];
    t = {8'h68, 8'(d.size() + 3), 8'(d.size() + 3), 8'h68, da, sa, fc};
    t = {t, d, s, 8'h16};
    foreach (t[i]) send_byte(t[i]);
  endtask
endmodule // fdp_master_model
`default_nettype wire

//--- verif/tb.sv
// tb: scenario bench for fdp_slave_port with a dp master model
// assumes 100 mhz clock, slave at address 3, master at address 2
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk_in;
  logic        rst_n_in;
  wire         line_rx;
  wire         tx_en;
  wire         exch;
  wire         frozen;
  wire         locked;
  wire         out_upd;
  wire  [7:0]  out_byte;
  logic        in_wr;
  logic        chan_wr;
  logic        nf;
  logic        chan_clr;
  logic [6:0]  st_addr;
  logic [7:0]  in_byte;
  wire         line_tx;
  logic [7:0]  rsp[$];
  logic [31:0] mf;
  logic [7:0]  out_idx;
  logic [7:0]  io_len;
  int          miscompares;
  int          n_compared;
  int          n_upd = 0;
  fdp_master_model m (.line_out(line_rx));
  fdp_slave_port #(.LOCK_EDGES(4'h4)) dut (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .line_rx_in(line_rx), .line_tx_out(line_tx),
    .line_tx_en_out(tx_en), .station_addr_in(st_addr), .in_wr_in(in_wr), .in_idx_in(out_idx),
    .in_byte_in(in_byte), .in_len_in(io_len), .out_idx_in(out_idx), .out_byte_out(out_byte),
    .out_len_in(io_len), .out_update_out(out_upd), .cfg_len_in(8'h02), .cfg_sum_in(8'h32),
    .node_fault_in(nf), .mod_fault_in(mf), .chan_wr_in(chan_wr), .chan_clr_in(chan_clr),
    .chan_entry_in(24'h00_0102), .exchange_out(exch), .frozen_out(frozen), .baud_locked_out(locked));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) if (out_upd) n_upd <= n_upd + 1;
  task automatic end_of_test;
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tel(input logic [7:0] da, d[$], output logic got);
    logic [7:0] b;
    got = 1'b0;
    rsp = {};
    m.send_tel(da, {da[7], 7'h02}, 8'h6d, d);
    for (int i = 0; i < 600 && !got; i++) @(posedge mclk_in) got = tx_en;
    for (int n = 0; n < 40 && tx_en; n++) begin
      for (int i = 0; i < 400 && tx_en && line_tx; i++) @(posedge mclk_in);
      if (tx_en && !line_tx) begin
        #(m.BIT_NS * 1.5);
        for (int k = 0; k < 8; k++) begin
          b[k] = line_tx;
          #(m.BIT_NS);
        end
        #(m.BIT_NS);
        rsp.push_back(b);
      end
    end
    if (tx_en !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic t_lock;
    m.lock_seq();
    for (int i = 0; i < 5000 && !locked; i++) @(posedge mclk_in);
    chk("lock", {7'h0, locked}, 8'h01);
  endtask
  task automatic t_diag;
    logic got;
    nf <= 1'b1;
    mf <= 32'h0000_0005;
    in_wr <= 1'b1;
    chan_wr <= 1'b1;
    @(posedge mclk_in);
    in_wr <= 1'b0;
    chan_wr <= 1'b0;
    tel(8'h84, {8'h3c, 8'h3e}, got);
    chk("foreign", {7'h0, got}, 8'h00);
    st_addr <= 7'h00;
    tel(8'h80, {8'h3c, 8'h3e}, got);
    chk("addr0", {7'h0, got}, 8'h00);
    st_addr <= 7'h03;
    tel(8'h83, {8'h3c, 8'h3e}, got);
    chk("diag", {7'h0, got}, 8'h01);
    chk("diag_len", 8'(rsp.size()), 8'd25);
    chk("status1", rsp[9], 8'h0a);
    chk("mod", rsp[16], 8'h05);
    chk("chan", rsp[20], 8'h02);
  endtask
  task automatic t_prm(input int n, input logic [7:0] e);
    logic got;
    logic [7:0] d[$];
    d = {8'h3d, 8'h3e};
    repeat (n) d.push_back(8'h00);
    tel(8'h83, d, got);
    tel(8'h83, {8'h3e, 8'h3e, 8'h11, 8'h21}, got);
    chk("sc", rsp[0], 8'he5);
    tel(8'h03, {8'ha5, 8'h3c}, got);
    chk("fc", rsp[6], e[0] ? 8'h08 : 8'h0c);
    if (e[0])
      chk("in0", rsp[7], 8'h5a);
    chk("exch", {7'h0, exch}, e);
    chk("upd", n_upd[7:0], e);
  endtask
  task automatic t_out;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk_in);
      out_idx <= (i == 2) ? 8'hf0 : 8'(i);
      @(posedge mclk_in);
      @(negedge mclk_in);
      chk("out", out_byte, (i == 0) ? 8'ha5 : (i == 1) ? 8'h3c : 8'h00);
    end
  endtask
  task automatic t_gc(input logic [7:0] ctl, e);
    logic got;
    tel(8'hff, {8'h3a, 8'h3e, ctl, 8'h00}, got);
    chk("frozen", {7'h0, frozen}, e);
  endtask
  initial begin
    rst_n_in = 1'b0;
    in_wr = 1'b0;
    chan_wr = 1'b0;
    nf = 1'b0;
    chan_clr = 1'b0;
    st_addr = 7'h03;
    in_byte = 8'h5a;
    mf = 32'h0000_0000;
    out_idx = 8'h00;
    io_len = 8'h02;
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    t_lock();
    t_diag();
    t_prm(16, 8'h00);
    t_prm(15, 8'h01);
    t_out();
    t_gc(8'h08, 8'h01);
    t_gc(8'h04, 8'h00);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
